// ===== design/rpsf_pkg.sv
/*
 * rpsf_pkg: constants and carrier types for the receive-port status flags.
 * Assumes: one core clock; the receive-port logic that feeds the block
 * runs on that same clock.
 */
package rpsf_pkg;

    // ************************************************************
    // register offsets and reset values
    // ************************************************************
    localparam logic [7:0] port_select_offset = 8'h4c;
    localparam logic [7:0] status_a_offset = 8'h4d;
    localparam logic [7:0] status_b_offset = 8'h4e;
    localparam logic [7:0] status_reset = 8'h00;
    localparam logic [7:0] unmapped_data = 8'h00;

    // ************************************************************
    // status a field positions
    // ************************************************************
    localparam int a_port_num_bit = 6;
    localparam int a_checksum_fault_bit = 5;
    localparam int a_lock_changed_bit = 4;
    localparam int a_order_fault_bit = 3;
    localparam int a_parity_over_bit = 2;
    localparam int a_pass_bit = 1;
    localparam int a_locked_bit = 0;

    // ************************************************************
    // status b field positions
    // ************************************************************
    localparam int b_length_unsteady_bit = 7;
    localparam int b_length_changed_bit = 6;
    localparam int b_encoding_fault_bit = 5;
    localparam int b_buffer_overflow_bit = 4;
    localparam int b_protocol_error_bit = 3;
    localparam int b_frequency_settled_bit = 2;
    localparam int b_cable_fault_bit = 1;
    localparam int b_count_changed_bit = 0;

    // events and live levels from one receive port, all core-clock
    typedef struct packed {
        logic checksum_fault;      // pulse: control channel crc error
        logic order_fault;         // pulse: control channel sequence error
        logic length_unsteady;     // pulse: frame with uneven lines
        logic length_changed;      // pulse: line length change
        logic encoding_fault;      // pulse: link encoding error
        logic buffer_overflow;     // pulse: packet buffer overflow
        logic count_changed;       // pulse: line count change
        logic parity_over;         // pulse/level: count above limit
        logic parity_cleared;      // pulse: parity counters cleared
        logic receiver_locked;     // level
        logic pass;                // level
        logic protocol_error;      // level
        logic frequency_settled;   // level
        logic clock_detected;      // level
        logic link_expected;       // level
    } rpsf_port_in_type;

endpackage

// ===== design/rpsf_status.sv
/*
 * rpsf_status: per-port copies of the two receive-port status registers,
 * with clear-on-read event flags and a port-selected read path.
 * Assumes: the port-select register lives elsewhere and hands in its
 * read-port field; register reads arrive as a one-cycle strobe with an
 * address, on the core clock.
 */
`timescale 1ns/1ps

// Summary of operation
// - each receive port owns a copy of both status registers.
// - the read-port field picks which port copy a read returns.
// - status a bit 6 reads back the selected read port number.
// - status a bit 5 sets on control checksum error, clears on read.
// - status a bit 4 sets on lock change since last read, clears on read.
// - status a bit 3 sets on control sequence error, clears on read.
// - parity flag ignores its own read, clears when counters clear.
// - status a bit 1 shows live pass status of the receive input.
// - status a bit 0 shows live receiver lock.
// - status b bit 7 sets on frame with uneven lines, holds until read.
// - status b bit 6 sets on line length change, clears on read.
// - status b bit 5 sets on link encoding error, clears on read.
// - status b bit 3 is read-only summary of a protocol receive error.
// - status b bit 1 flags cable fault: no clock while link expected.
// - status b bit 0 sets on line count change, clears on read.
module rpsf_status #(
    parameter int num_ports = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic read_port,
    input wire logic rd_stb,
    input wire logic [7:0] rd_addr,
    input wire rpsf_pkg::rpsf_port_in_type port_in [num_ports],
    output logic [7:0] rd_data_reg,
    output logic rd_valid_reg
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    // the read-port field is one bit wide, so two ports at most
    if (num_ports < 1 || num_ports > 2) begin : g_bad_ports
        $error("rpsf_status: num_ports must be 1 or 2");
    end

    // ************************************************************
    // address decode
    // ************************************************************
    // a read only clears the copy it actually returned
    wire logic hit_a;
    wire logic hit_b;
    wire logic [7:0] sel_a;
    wire logic [7:0] sel_b;
    logic [7:0] stat_a [num_ports];
    logic [7:0] stat_b [num_ports];
    logic [7:0] rd_data_next;

    assign hit_a = rd_stb && (rd_addr == rpsf_pkg::status_a_offset);
    assign hit_b = rd_stb && (rd_addr == rpsf_pkg::status_b_offset);
    // an absent port reads as the reset value
    assign sel_a = (int'(read_port) < num_ports) ?
                   stat_a[read_port] : rpsf_pkg::status_reset;
    assign sel_b = (int'(read_port) < num_ports) ?
                   stat_b[read_port] : rpsf_pkg::status_reset;

    // ************************************************************
    // per-port register copies
    // ************************************************************
    for (genvar p = 0; p < num_ports; p++) begin : g_port
        logic checksum_reg;
        logic lock_chg_reg;
        logic order_reg;
        logic parity_reg;
        logic lock_prev_reg;
        logic unsteady_reg;
        logic len_chg_reg;
        logic encode_reg;
        logic overflow_reg;
        logic cnt_chg_reg;
        wire logic checksum_next;
        wire logic lock_chg_next;
        wire logic order_next;
        wire logic parity_next;
        wire logic unsteady_next;
        wire logic len_chg_next;
        wire logic encode_next;
        wire logic overflow_next;
        wire logic cnt_chg_next;
        wire logic clr_a;
        wire logic clr_b;
        wire logic lock_toggle;
        wire rpsf_pkg::rpsf_port_in_type pin;

        assign pin = port_in[p];
        assign clr_a = hit_a && (int'(read_port) == p);
        assign clr_b = hit_b && (int'(read_port) == p);
        // lock is compared against the previous cycle's level
        assign lock_toggle = pin.receiver_locked != lock_prev_reg;

        // status a events: the event term wins over a same-cycle clear,
        // so a fault landing on the clearing read is never lost
        assign checksum_next = pin.checksum_fault
                               || (checksum_reg && !clr_a);
        assign lock_chg_next = lock_toggle
                               || (lock_chg_reg && !clr_a);
        assign order_next = pin.order_fault
                            || (order_reg && !clr_a);

        // status b events, cleared only by a read of status b
        assign unsteady_next = pin.length_unsteady
                               || (unsteady_reg && !clr_b);
        assign len_chg_next = pin.length_changed
                              || (len_chg_reg && !clr_b);
        assign encode_next = pin.encoding_fault
                             || (encode_reg && !clr_b);
        assign overflow_next = pin.buffer_overflow
                               || (overflow_reg && !clr_b);
        assign cnt_chg_next = pin.count_changed
                              || (cnt_chg_reg && !clr_b);

        // parity flag is deaf to reads; only a counter clear drops it,
        // and a fresh over-limit report beats a clear in the same cycle
        assign parity_next = pin.parity_over
                             || (parity_reg && !pin.parity_cleared);

        // status a flag registers
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                checksum_reg <= 1'b0;
                lock_chg_reg <= 1'b0;
                order_reg <= 1'b0;
            end else begin
                checksum_reg <= checksum_next;
                lock_chg_reg <= lock_chg_next;
                order_reg <= order_next;
            end
        end

        // status b flag registers
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                unsteady_reg <= 1'b0;
                len_chg_reg <= 1'b0;
                encode_reg <= 1'b0;
                overflow_reg <= 1'b0;
                cnt_chg_reg <= 1'b0;
            end else begin
                unsteady_reg <= unsteady_next;
                len_chg_reg <= len_chg_next;
                encode_reg <= encode_next;
                overflow_reg <= overflow_next;
                cnt_chg_reg <= cnt_chg_next;
            end
        end

        // parity flag and lock history; history restarts as unlocked
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                parity_reg <= 1'b0;
                lock_prev_reg <= 1'b0;
            end else begin
                parity_reg <= parity_next;
                lock_prev_reg <= pin.receiver_locked;
            end
        end

        // assemble the two views; reserved bit 7 of status a reads zero
        always_comb begin
            stat_a[p] = rpsf_pkg::status_reset;
            stat_a[p][rpsf_pkg::a_port_num_bit] = read_port;
            stat_a[p][rpsf_pkg::a_checksum_fault_bit] = checksum_reg;
            stat_a[p][rpsf_pkg::a_lock_changed_bit] = lock_chg_reg;
            stat_a[p][rpsf_pkg::a_order_fault_bit] = order_reg;
            stat_a[p][rpsf_pkg::a_parity_over_bit] = parity_reg;
            stat_a[p][rpsf_pkg::a_pass_bit] = pin.pass;
            stat_a[p][rpsf_pkg::a_locked_bit] = pin.receiver_locked;
            stat_b[p] = rpsf_pkg::status_reset;
            stat_b[p][rpsf_pkg::b_length_unsteady_bit] = unsteady_reg;
            stat_b[p][rpsf_pkg::b_length_changed_bit] = len_chg_reg;
            stat_b[p][rpsf_pkg::b_encoding_fault_bit] = encode_reg;
            stat_b[p][rpsf_pkg::b_buffer_overflow_bit] = overflow_reg;
            stat_b[p][rpsf_pkg::b_protocol_error_bit] =
                pin.protocol_error;
            stat_b[p][rpsf_pkg::b_frequency_settled_bit] =
                pin.frequency_settled;
            stat_b[p][rpsf_pkg::b_cable_fault_bit] =
                pin.link_expected && !pin.clock_detected;
            stat_b[p][rpsf_pkg::b_count_changed_bit] = cnt_chg_reg;
        end
    end

    // ************************************************************
    // read return
    // ************************************************************
    // unmapped addresses answer with a fixed zero byte
    always_comb begin
        rd_data_next = rpsf_pkg::unmapped_data;
        if (hit_a) begin
            rd_data_next = sel_a;
        end else if (hit_b) begin
            rd_data_next = sel_b;
        end
    end

    // data is captured with the flag values before the clear lands
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data_reg <= rpsf_pkg::status_reset;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_stb;
            if (rd_stb) begin
                rd_data_reg <= rd_data_next;
            end
        end
    end

endmodule

// ===== tb/rpsf_status_properties.sv
/*
 * rpsf_status_properties: timing checks on the status read path.
 * Assumes: bound to rpsf_status, one core clock, async reset high.
 */
`timescale 1ns/1ps
module rpsf_status_properties #(
    parameter int num_ports = 2
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic read_port,
    input wire logic rd_stb,
    input wire logic [7:0] rd_addr,
    input wire rpsf_pkg::rpsf_port_in_type port_in [num_ports],
    input wire logic [7:0] rd_data_reg,
    input wire logic rd_valid_reg
);
    // ************************************************************
    // helpers: selected port and decoded reads
    // ************************************************************
    wire rpsf_pkg::rpsf_port_in_type sel = port_in[read_port];
    wire rd_a = rd_stb && rd_addr == 8'h4d;
    wire rd_b = rd_stb && rd_addr == 8'h4e;
    // live bits gathered so that $past sees plain signals
    wire [1:0] live_a_bits = {sel.pass, sel.receiver_locked};
    wire [2:0] live_b_bits = {sel.protocol_error, sel.frequency_settled,
        sel.link_expected & ~sel.clock_detected};
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // two reads of one port back to back, first without a new event
    sequence quiet_read_a;
        rd_a && !sel.checksum_fault;
    endsequence
    sequence again_a;
        rd_a && $stable(read_port);
    endsequence
    read_valid_a: assert property (rd_stb |=> rd_valid_reg)
        else $error("no valid after read");
    idle_valid_a: assert property (!rd_stb |=> !rd_valid_reg)
        else $error("valid without read");
    port_number_a: assert property (rd_a |=>
        rd_data_reg[7:6] == {1'b0, $past(read_port)})
        else $error("port number field wrong");
    live_a_a: assert property (rd_a |=>
        rd_data_reg[1:0] == $past(live_a_bits))
        else $error("live lock or pass wrong");
    live_b_a: assert property (rd_b |=> rd_data_reg[3:1] ==
        $past(live_b_bits))
        else $error("live status b bits wrong");
    unmapped_zero_a: assert property (rd_stb && !rd_a && !rd_b |=>
        rd_data_reg == 8'h00)
        else $error("unmapped read not zero");
    event_sets_a: assert property ((sel.checksum_fault && !rd_stb) ##1
        again_a |=> rd_data_reg[5])
        else $error("checksum flag not set");
    read_clears_a: assert property (quiet_read_a ##1
        (again_a and !sel.checksum_fault) |=> !rd_data_reg[5])
        else $error("checksum flag not cleared");
    event_kept_a: assert property ((rd_a && sel.checksum_fault) ##1
        again_a |=> rd_data_reg[5])
        else $error("same cycle event lost");
    parity_sticky_a: assert property ((sel.parity_over && !rd_stb) ##1
        (again_a and !sel.parity_cleared) ##1 again_a |=> rd_data_reg[2])
        else $error("parity flag cleared by read");
endmodule
bind rpsf_status rpsf_status_properties #(.num_ports(num_ports)) u_props (
    .clock(clock), .rst(rst), .read_port(read_port), .rd_stb(rd_stb),
    .rd_addr(rd_addr), .port_in(port_in), .rd_data_reg(rd_data_reg),
    .rd_valid_reg(rd_valid_reg));

// ===== tb/rpsf_link_model.sv
/*
 * rpsf_link_model: far-side link source for one receive port.
 * Assumes: requests change at the falling edge; event bits are cut to
 * one-cycle pulses even when the bench holds them longer.
 */
`timescale 1ns/1ps
module rpsf_link_model (
    input wire logic clock,
    input wire rpsf_pkg::rpsf_port_in_type req,
    output rpsf_pkg::rpsf_port_in_type port_out
);
    // ************************************************************
    // events pulse once, levels pass straight through
    // ************************************************************
    logic [14:0] seen_reg;
    always_ff @(posedge clock) begin
        seen_reg <= req & 15'h7fc0;
    end
    // a held request must not look like a stream of events
    assign port_out = req & ~seen_reg;
endmodule

// ===== tb/rpsf_status_bench.sv
/*
 * rpsf_status_bench: directed reads of both status registers.
 * Assumes: two ports, 20 MHz clock, inputs changed at the falling edge.
 */
`timescale 1ns/1ps
module rpsf_status_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic read_port = 1'b0;
    logic rd_stb = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    rpsf_pkg::rpsf_port_in_type lv [2];
    rpsf_pkg::rpsf_port_in_type req [2];
    rpsf_pkg::rpsf_port_in_type port_in [2];
    int n_errors = 0;
    int check_count = 0;
    rpsf_status #(.num_ports(2)) DUT (.clock(clock), .rst(rst),
        .read_port(read_port), .rd_stb(rd_stb), .rd_addr(rd_addr),
        .port_in(port_in), .rd_data_reg(rd_data_reg),
        .rd_valid_reg(rd_valid_reg));
    rpsf_link_model far0 (.clock(clock), .req(req[0]), .port_out(port_in[0]));
    rpsf_link_model far1 (.clock(clock), .req(req[1]), .port_out(port_in[1]));
    // ************************************************************
    // clock, compare and access tasks
    // ************************************************************
    initial forever #25 clock = ~clock;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // strobe stays high so calls run back to back
    task rd(input logic [7:0] a, input logic p, input logic [7:0] exp);
        rd_addr = a;
        read_port = p;
        rd_stb = 1'b1;
        @(negedge clock);
        chk({7'h00, rd_valid_reg}, 8'h01);
        chk(rd_data_reg, exp);
    endtask
    task fire(input int p, input logic [14:0] ev);
        req[p] = rpsf_pkg::rpsf_port_in_type'(lv[p] | ev);
        read_port = p[0];
        rd_stb = 1'b0;
        @(negedge clock);
        req[p] = lv[p];
    endtask
    task tally_and_finish;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ************************************************************
    // directed sequence
    // ************************************************************
    initial begin
        lv[0] = '0;
        lv[1] = '0;
        req = lv;
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        rd(8'h4d, 1'b0, 8'h00);
        rd(8'h4e, 1'b0, 8'h00);
        rd(8'h4d, 1'b1, 8'h40);
        rd(8'h4e, 1'b1, 8'h00);
        lv[0] = 15'h0030;
        fire(0, 15'h0000);
        fire(0, 15'h0000);
        rd(8'h4d, 1'b0, 8'h13);
        rd(8'h4d, 1'b0, 8'h03);
        rd(8'h4d, 1'b1, 8'h40);
        fire(1, 15'h6080);
        rd(8'h4d, 1'b1, 8'h6c);
        rd(8'h4d, 1'b1, 8'h44);
        rd(8'h4d, 1'b1, 8'h44);
        fire(1, 15'h0040);
        rd(8'h4d, 1'b1, 8'h40);
        lv[0] = 15'h003d;
        fire(0, 15'h1f00);
        rd(8'h4e, 1'b0, 8'hff);
        rd(8'h4e, 1'b0, 8'h0e);
        lv[0] = 15'h003f;
        fire(0, 15'h0000);
        rd(8'h4e, 1'b0, 8'h0c);
        // event lands in the very cycle of the clearing read
        req[0] = rpsf_pkg::rpsf_port_in_type'(lv[0] | 15'h4000);
        rd(8'h4d, 1'b0, 8'h03);
        req[0] = lv[0];
        rd(8'h4d, 1'b0, 8'h23);
        rd(8'h4d, 1'b0, 8'h03);
        rd(8'h4c, 1'b0, 8'h00);
        rd(8'h4f, 1'b1, 8'h00);
        // mid-run reset wipes a pending flag; lock history restarts at 0
        fire(0, 15'h0100);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        rd(8'h4e, 1'b0, 8'h0c);
        rd(8'h4d, 1'b0, 8'h13);
        rd(8'h4d, 1'b0, 8'h03);
        fire(0, 15'h0000);
        tally_and_finish;
    end
    // watchdog: the sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge clock);
        n_errors++;
        tally_and_finish;
    end
endmodule
